// [seep_asserts.sv]
// assertions on the two-wire link and the write cycle flag
`timescale 1ns/1ps
module seep_asserts #(
  parameter int WRITE_CYC = 50
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic BUSY,
  input wire logic scl,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic sda
);
  logic       p_scl;
  logic       p_sda;
  logic       in_frame;
  logic [7:0] since_stop;
  int         busy_cnt;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  // start and stop seen on raw lines; counter saturates so it never wraps
  always_ff @(posedge MCLK) begin
    p_scl <= scl;
    p_sda <= sda;
    if (RST) begin
      in_frame   <= 1'b0;
      since_stop <= 8'hff;
      busy_cnt   <= 0;
    end else begin
      if (scl && p_scl && p_sda && !sda)
        in_frame <= 1'b1;
      if (scl && p_scl && !p_sda && sda) begin
        in_frame   <= 1'b0;
        since_stop <= 8'h00;
      end else if (since_stop != 8'hff)
        since_stop <= since_stop + 8'h01;
      busy_cnt <= BUSY ? busy_cnt + 1 : 0;
    end
  end

  chk_busy_quiet: assert property (BUSY |-> !sda_s_oe)
    else $error("device drives data in write cycle");
  chk_busy_hold: assert property ($rose(BUSY) |-> BUSY[*8])
    else $error("write cycle ended at once");
  chk_busy_length: assert property ($fell(BUSY) |-> busy_cnt >= WRITE_CYC - 1 && busy_cnt <= WRITE_CYC + 1)
    else $error("write cycle length wrong");
  chk_busy_after_stop: assert property ($rose(BUSY) |-> since_stop <= 8'h0a)
    else $error("write cycle not started by stop");
  chk_drive_low: assert property ($rose(sda_s_oe) |-> !scl)
    else $error("device pulls data with clock high");
  chk_release_low: assert property ($fell(sda_s_oe) |-> !scl)
    else $error("device releases data with clock high");
  chk_ack_steady: assert property (($rose(scl) && sda_s_oe) |-> sda_s_oe[*3])
    else $error("device bit changed with clock high");
  chk_idle_quiet: assert property ((!in_frame && since_stop > 8'h04) |-> !sda_s_oe)
    else $error("device drives data outside a frame");
endmodule : seep_asserts

// [seep_dev.sv]
// eeprom slave: serial protocol, array, protect register and write timer
`timescale 1ns/1ps
module seep_dev
  import seep_pkg::*;
#(
  parameter int WRITE_CYC = WRITE_CYCLES
) (
  input  wire logic MCLK,
  input  wire logic RST,
  input  wire logic WP,
  output logic      BUSY,
  seep_if.dev       LINK
);
  typedef enum logic [2:0] {ST_IDLE, ST_SADDR, ST_AHI, ST_ALO, ST_WDATA, ST_RDATA, ST_RACK, ST_IGNORE} seep_st_type;
  typedef struct packed {
    logic [2:0]        scl_s;
    logic [2:0]        sda_s;
    logic [1:0]        wp_s;
    seep_st_type       st;
    logic [3:0]        bitc;
    logic [7:0]        sh;
    logic              ack_slot;
    logic              ack_go;
    logic              drive;
    logic [15:0]       wa;
    logic [ADDR_W-1:0] ptr;
    logic              reg_sel;
    logic [7:0]        reg_data;
    logic [5:0]        nbytes;
    logic              pend;
    logic              pend_reg;
    logic [ADDR_W-PAGE_BITS-1:0] page;
    logic [PAGE_BYTES-1:0] dirty;
    logic [7:0]        wr_latch;
    logic              hw_protect_enable;
    logic              lock_select_high;
    logic              lock_select_low;
    logic              register_write_latch;
    logic              write_enable_latch;
    logic [31:0]       timer;
    logic              busy;
  } seep_dev_type;
  seep_dev_type r, next_r;
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0] page_buf [0:PAGE_BYTES-1];
  logic [7:0] rd_byte;
  logic       scl_rise, scl_fall, start_c, stop_c, hw_lock, locked;
  logic [7:0] reg_val;

  // only stages 1 and 2 feed edge detection, stage 0 is the sync flop
  assign scl_rise = r.scl_s[1] && !r.scl_s[2];
  assign scl_fall = !r.scl_s[1] && r.scl_s[2];
  assign start_c  = r.scl_s[1] && r.scl_s[2] && !r.sda_s[1] && r.sda_s[2];
  assign stop_c   = r.scl_s[1] && r.scl_s[2] && r.sda_s[1] && !r.sda_s[2];
  // pin and enable; the pin is asynchronous so only its synchronised copy is read
  assign hw_lock  = r.wp_s[1] && r.hw_protect_enable;
  assign reg_val  = {r.hw_protect_enable, 2'b00, r.lock_select_high, r.lock_select_low,
                     r.register_write_latch, r.write_enable_latch, 1'b0};
  always_comb begin
    unique case ({r.lock_select_high, r.lock_select_low})
      2'b00: locked = 1'b0;
      2'b01: locked = r.wa[11:0] >= LOCK_QUARTER;
      2'b10: locked = r.wa[11:0] >= LOCK_HALF;
      2'b11: locked = 1'b1;
    endcase
  end
  assign rd_byte = r.reg_sel ? reg_val : mem[r.ptr];

  always_comb begin
    next_r       = r;
    next_r.scl_s = {r.scl_s[1:0], LINK.scl};
    next_r.sda_s = {r.sda_s[1:0], LINK.sda};
    next_r.wp_s  = {r.wp_s[0], WP};
    // write timer, inputs ignored while it runs
    if (r.busy) begin
      next_r.timer = r.timer - 32'd1;
      if (r.timer == 32'd1) begin
        next_r.busy = 1'b0;
      end
    end else if (stop_c) begin
      next_r.st     = ST_IDLE;
      next_r.drive  = 1'b0;
      if (r.pend) begin
        next_r.busy  = 1'b1;
        next_r.timer = 32'(WRITE_CYC);
        next_r.pend  = 1'b0;
        next_r.register_write_latch = 1'b0;
        if (r.pend_reg) begin
          next_r.hw_protect_enable = r.wr_latch[BIT_HWEN];
          next_r.lock_select_high  = r.wr_latch[BIT_LOCK_HIGH];
          next_r.lock_select_low   = r.wr_latch[BIT_LOCK_LOW];
        end
      end
    end else if (start_c) begin
      next_r.st     = ST_SADDR;
      next_r.bitc   = 4'd0;
      next_r.drive  = 1'b0;
      next_r.pend   = 1'b0;
      next_r.ack_slot = 1'b0;
    end else if (scl_rise && r.st != ST_IDLE && r.st != ST_IGNORE && !r.ack_slot) begin
      next_r.sh   = {r.sh[6:0], r.sda_s[1]};
      next_r.bitc = r.bitc + 4'd1;
      // master nack ends read, an ack waits for the fall to load the next byte
      if (r.st == ST_RACK && r.bitc == 4'd0 && r.sda_s[1]) begin
        next_r.st = ST_IGNORE;
      end
    end else if (scl_fall && r.ack_slot) begin
      // ack clock finished, release and enter next phase
      next_r.ack_slot = 1'b0;
      next_r.drive    = 1'b0;
      next_r.bitc     = 4'd0;
      if (r.st == ST_RDATA) begin
        next_r.drive = !rd_byte[7];
      end
    end else if (scl_fall && r.bitc == 4'd8 && r.st != ST_RDATA && r.st != ST_RACK) begin
      next_r.ack_slot = 1'b1;
      next_r.ack_go   = 1'b0;
      unique case (r.st)
        ST_SADDR: begin
          if (r.sh[7:1] == DEV_TYPE) begin
            next_r.ack_go = 1'b1;
            next_r.st     = r.sh[0] ? ST_RDATA : ST_AHI;
            next_r.sh     = 8'h00;
          end else begin
            next_r.st = ST_IGNORE;
          end
        end
        ST_AHI: begin
          next_r.wa[15:8] = r.sh;
          next_r.ack_go   = 1'b1;
          next_r.st       = ST_ALO;
        end
        ST_ALO: begin
          // address loaded into counter, only all ones selects the register
          next_r.wa[7:0] = r.sh;
          next_r.ack_go  = 1'b1;
          next_r.reg_sel = {r.wa[15:8], r.sh} == REG_ADDR;
          next_r.ptr     = {r.wa[11:8], r.sh};
          next_r.nbytes  = 6'd0;
          next_r.dirty   = '0;
          // page comes from the bytes just received, the low byte of wa still holds the old one
          next_r.page    = {r.wa[ADDR_W-1:8], r.sh[7:PAGE_BITS]};
          next_r.st      = ST_WDATA;
        end
        ST_WDATA: begin
          if (r.reg_sel) begin
            if (r.nbytes == 6'd0) begin
              next_r.ack_go = 1'b1;
              next_r.nbytes = 6'd1;
              if ((r.sh & RSVD_MASK) == 8'h00) begin
                if (r.register_write_latch && !r.sh[BIT_REG_LATCH]) begin
                  next_r.pend     = !hw_lock;
                  next_r.pend_reg = 1'b1;
                  next_r.wr_latch = r.sh;
                  if (hw_lock) begin
                    next_r.register_write_latch = 1'b0;
                  end
                end else if (!r.register_write_latch) begin
                  next_r.write_enable_latch   = r.sh[BIT_WR_LATCH];
                  next_r.register_write_latch = r.sh[BIT_REG_LATCH] && r.write_enable_latch && r.sh[BIT_WR_LATCH];
                end
              end
            end
          end else if (r.write_enable_latch) begin
            // data acked only with write enable
            next_r.ack_go = 1'b1;
            if (!locked) begin
              next_r.pend     = 1'b1;
              next_r.pend_reg = 1'b0;
              next_r.dirty[r.ptr[PAGE_BITS-1:0]] = 1'b1;
            end
            next_r.ptr[PAGE_BITS-1:0] = r.ptr[PAGE_BITS-1:0] + 5'd1;
          end else begin
            next_r.st = ST_IGNORE;
          end
        end
        default: next_r.st = ST_IGNORE;
      endcase
      next_r.drive = next_r.ack_go;
      if (!next_r.ack_go) begin
        next_r.ack_slot = 1'b0;
      end
    end else if (scl_fall && r.st == ST_RDATA) begin
      // shift out byte msb first
      // msb went out at the end of the ack, seven more falls shift the rest and the eighth ends the byte
      if (r.bitc == 4'd7) begin
        next_r.drive = 1'b0;
        next_r.st    = ST_RACK;
        next_r.bitc  = 4'd0;
        // register read resets counter, array wraps
        if (r.reg_sel) begin
          next_r.ptr     = '0;
          next_r.reg_sel = 1'b0;
          next_r.st      = ST_IGNORE;
        end else begin
          next_r.ptr = r.ptr + 12'd1;
        end
      end else begin
        next_r.drive = !rd_byte[3'd6 - r.bitc[2:0]];
      end
    end else if (scl_fall && r.st == ST_RACK && r.bitc == 4'd1) begin
      next_r.drive = !rd_byte[7];
      next_r.bitc  = 4'd0;
      next_r.st    = ST_RDATA;
    end
    next_r.bitc = (r.st == ST_RDATA && scl_fall && !r.ack_slot && r.bitc != 4'd7) ? r.bitc + 4'd1 : next_r.bitc;
    if (scl_rise && r.st == ST_RDATA) begin
      next_r.bitc = r.bitc;
      next_r.sh   = r.sh;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      r <= '0;
      r.scl_s <= 3'b111;
      r.sda_s <= 3'b111;
    end else begin
      r <= next_r;
    end
  end

  // array and page buffer; committed to the array when the timer finishes
  always_ff @(posedge MCLK) begin
    if (!r.busy && scl_fall && r.bitc == 4'd8 && r.st == ST_WDATA && !r.reg_sel && r.write_enable_latch && !locked) begin
      page_buf[r.ptr[PAGE_BITS-1:0]] <= r.sh;
    end
    if (r.busy && r.timer == 32'd1 && !r.pend_reg) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (r.dirty[i]) begin
          mem[{r.page, 5'(i)}] <= page_buf[i];
        end
      end
    end
  end

  assign LINK.sda_s_oe = r.drive;
  assign BUSY          = r.busy;
endmodule : seep_dev

// [seep_host.sv]
// bus master: apb register port drives single byte read and write transfers
`timescale 1ns/1ps
module seep_host
  import seep_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  seep_if.host             LINK
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_DONE} seep_hst_type;
  typedef struct packed {
    seep_hst_type st;
    logic [1:0]   sda_s;
    logic [15:0]  addr;
    logic [7:0]   wdata;
    logic [7:0]   rdata;
    logic         rd;
    logic         nack;
    logic [5:0]   bitn;
    logic [2:0]   div;
    logic         scl;
    logic         sda_oe;
    logic         ph;
    logic [31:0]  prdata;
    logic         pready;
  } seep_host_type;
  seep_host_type r, next_r;
  logic [45:0] frame;
  // dummy write then read address, one frame of bits; bit 27 of a read is the restart slot
  assign frame = r.rd ? {DEV_TYPE, 1'b0, 1'b1, r.addr[15:8], 1'b1, r.addr[7:0], 2'b11, DEV_TYPE, 2'b11, 8'hff, 1'b1}
                      : {DEV_TYPE, 1'b0, 1'b1, r.addr[15:8], 1'b1, r.addr[7:0], 1'b1, r.wdata, 1'b1, 10'h3ff};

  always_comb begin
    next_r        = r;
    next_r.sda_s  = {r.sda_s[0], LINK.sda};
    next_r.pready = 1'b0;
    next_r.div    = r.div + 3'd1;
    unique case (r.st)
      H_IDLE: begin
        next_r.div = 3'd0;
        // writes land at the edge that completes the access, when ready is seen high
        if (PSEL && PENABLE && r.pready && PWRITE && PADDR == OFS_ADDR) next_r.addr = PWDATA[15:0];
        if (PSEL && PENABLE && r.pready && PWRITE && PADDR == OFS_WDATA) next_r.wdata = PWDATA[7:0];
        if (PSEL && PENABLE && r.pready && PWRITE && PADDR == OFS_CMD) begin
          next_r.rd   = PWDATA[0];
          next_r.st   = H_START;
          next_r.nack = 1'b0;
        end
      end
      H_START: begin
        if (r.div == 3'(SCL_HALF)) begin
          next_r.div    = 3'd0;
          next_r.sda_oe = 1'b1;
          next_r.ph     = ~r.ph;
          if (r.ph) begin
            next_r.scl    = 1'b0;
            next_r.bitn   = 6'd0;
            next_r.st     = H_BIT;
            next_r.sda_oe = !frame[45];
          end
        end
      end
      H_BIT: begin
        if (r.div == 3'(SCL_HALF)) begin
          next_r.div = 3'd0;
          next_r.scl = ~r.scl;
          // falling edge: the bit just clocked is sampled and the next one set up
          if (r.scl) begin
            next_r.bitn = r.bitn + 6'd1;
            // slave acknowledge slots only; the master's own nack is not counted
            if (r.bitn == 6'd8 || r.bitn == 6'd17 || r.bitn == 6'd26 || r.bitn == (r.rd ? 6'd36 : 6'd35)) begin
              next_r.nack = r.nack | r.sda_s[1];
            end
            if (r.rd && r.bitn >= 6'd37 && r.bitn < 6'd45) next_r.rdata = {r.rdata[6:0], r.sda_s[1]};
            // a write stops right after the data acknowledge
            if (r.bitn == 6'd45 || (!r.rd && r.bitn == 6'd35)) begin
              next_r.st     = H_STOP;
              next_r.sda_oe = 1'b1;
            end else begin
              next_r.sda_oe = !frame[6'd44 - r.bitn];
            end
          end
        end
        // repeated start: data falls in the middle of the released high phase
        if (r.rd && r.bitn == 6'd27 && r.scl && r.div == 3'd2) begin
          next_r.sda_oe = 1'b1;
        end
      end
      H_STOP: begin
        if (r.div == 3'(SCL_HALF)) begin
          next_r.div = 3'd0;
          next_r.ph  = ~r.ph;
          if (!r.ph) next_r.scl = 1'b1;
          else begin
            next_r.sda_oe = 1'b0;
            next_r.st     = H_DONE;
          end
        end
      end
      H_DONE: next_r.st = H_IDLE;
      default: next_r.st = H_IDLE;
    endcase
    if (PSEL && PENABLE && !r.pready) begin
      next_r.pready = 1'b1;
      next_r.prdata = (PADDR == OFS_STATUS) ? {22'h0, r.nack, r.st != H_IDLE, r.rdata} : 32'h0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      r       <= '0;
      r.scl   <= 1'b1;
      r.sda_s <= 2'b11;
    end else begin
      r <= next_r;
    end
  end

  assign LINK.scl      = r.scl;
  assign LINK.sda_m_oe = r.sda_oe;
  assign PRDATA        = r.prdata;
  assign PREADY        = r.pready;
  assign PSLVERR       = 1'b0;
endmodule : seep_host

// [seep_if.sv]
// two-wire link between the bus master and the eeprom
`timescale 1ns/1ps
interface seep_if;
  logic scl;
  logic sda_m_oe;
  logic sda_s_oe;
  logic sda;
  assign sda = !(sda_m_oe || sda_s_oe);   // open drain with pull-up, enables pull low
  modport dev (input scl, input sda, output sda_s_oe);
  modport host (output scl, output sda_m_oe, input sda);
endinterface : seep_if

// [seep_pkg.sv]
// package of constants shared by both ends of the serial eeprom link
// Notes on behaviour
// - byte write: ack address, data, stop starts write
// - busy write cycle ignores bus, releases data
// - page write takes 32 bytes, acks each
// - page address wraps inside page, overwrites
// - polling gets no ack while busy
// - address counter is last address plus one
// - read address byte acked, then data shifted
// - master ends read by nack then stop
// - random read: dummy write then repeated start
// - stop after address sets counter only
// - sequential read walks array, wraps to zero
// - protect register written only at ffff
// - nonzero reserved bits block register update
// - register write acks first byte only
// - register read returns contents, counter zero
// - protect register bit layout
// - latches permit or block writes
// - locked write acked, discarded, no cycle
// - pin plus enable blocks nonvolatile protect
// - lock selects cover quarter, half, whole
// - write enable latch set and cleared
// - three step sequence changes protect bits
// - register latch clears after nonvolatile write
package seep_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          PAGE_BYTES    = 32;
  localparam int          PAGE_BITS     = 5;
  localparam logic [15:0] REG_ADDR      = 16'hffff;
  localparam logic [6:0]  DEV_TYPE      = 7'h50;    // slave address upper bits, arbitrary select bits 000
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam int          BIT_HWEN      = 7;
  localparam int          BIT_LOCK_HIGH = 4;
  localparam int          BIT_LOCK_LOW  = 3;
  localparam int          BIT_REG_LATCH = 2;
  localparam int          BIT_WR_LATCH  = 1;
  localparam logic [7:0]  RSVD_MASK     = 8'h61;
  localparam logic [11:0] LOCK_QUARTER  = 12'hc00;
  localparam logic [11:0] LOCK_HALF     = 12'h800;
  localparam real         WRITE_TIME_US = 5000.0;
  localparam real         CLK_MHZ       = 20.0;
  localparam int          WRITE_CYCLES  = int'(WRITE_TIME_US * CLK_MHZ);
  localparam int          SCL_HALF      = 4;        // controller scl half period is this count plus one, 5 clocks
  // controller register offsets
  localparam logic [7:0]  OFS_CMD       = 8'h00;
  localparam logic [7:0]  OFS_ADDR      = 8'h04;
  localparam logic [7:0]  OFS_WDATA     = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0c;
endpackage : seep_pkg

// [tb.sv]
// testbench: apb driven controller talking to the eeprom across the link
`timescale 1ns/1ps
module tb
  import seep_pkg::*;
;
  localparam int WCYC = 400;   // long enough that a poll lands inside it
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        wp = 1'b0;
  logic        busy;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic [31:0] st;
  logic [7:0]  bad [3] = '{8'h03, 8'h22, 8'h46};
  int          errors = 0;
  int          check_count = 0;

  seep_if link ();
  seep_dev #(.WRITE_CYC(WCYC)) seep_dev_i (.MCLK(mclk), .RST(rst), .WP(wp), .BUSY(busy), .LINK(link.dev));
  seep_host seep_host_i (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(), .LINK(link.host));
  seep_asserts #(.WRITE_CYC(WCYC)) seep_asserts_i (.MCLK(mclk), .RST(rst), .BUSY(busy), .scl(link.scl),
    .sda_m_oe(link.sda_m_oe), .sda_s_oe(link.sda_s_oe), .sda(link.sda));

  always #25 mclk = ~mclk;

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; a clock passes after release so strobes never toggle twice
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    st = prdata;
    if (pready !== 1'b1) check(10'h3ff, 10'h000);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  // one byte transfer, then poll status until the controller is idle
  task automatic xfer(input logic rd, input logic [15:0] a, input logic [7:0] d);
    int n;
    apb(1'b1, OFS_ADDR, {16'h0, a});
    apb(1'b1, OFS_WDATA, {24'h0, d});
    apb(1'b1, OFS_CMD, {31'h0, rd});
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (st[8] !== 1'b0 && n < 3000);
    check({9'h0, st[8]}, 10'h000);
  endtask : xfer

  // busy must match exp within a few clocks of the stop
  task automatic expect_busy(input logic exp);
    int n;
    n = 0;
    while (busy !== exp && n < 20) begin
      @(posedge mclk);
      n++;
    end
    repeat (4) @(posedge mclk);
    check({9'h0, busy}, {9'h0, exp});
  endtask : expect_busy

  task automatic settle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2 * WCYC) begin
      @(posedge mclk);
      n++;
    end
    check({9'h0, busy}, 10'h000);
  endtask : settle

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (40000) @(posedge mclk);
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    print_verdict;
  end

  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // latch set is volatile, no write cycle
    xfer(1'b0, 16'hffff, 8'h02);
    expect_busy(1'b0);
    xfer(1'b1, 16'hffff, 8'h00);
    check(st[9:0], 10'h002);
    $display("test latch done");
    // byte write, then a request while the cycle runs
    xfer(1'b0, 16'h0c00, 8'ha5);
    settle;
    xfer(1'b0, 16'h0123, 8'h5a);
    check(st[9:0] & 10'h200, 10'h000);
    expect_busy(1'b1);
    xfer(1'b0, 16'h0124, 8'h11);
    check(st[9:0] & 10'h200, 10'h200);
    settle;
    xfer(1'b1, 16'h0123, 8'h00);
    check(st[9:0], 10'h05a);
    $display("test byte write done");
    // register refuses other addresses and bytes with reserved ones
    xfer(1'b0, 16'h7fff, 8'h06);
    settle;
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, 16'hffff, bad[i]);
      expect_busy(1'b0);
    end
    xfer(1'b1, 16'hffff, 8'h00);
    check(st[9:0], 10'h002);
    $display("test refusals done");
    // three steps lock the upper quarter
    xfer(1'b0, 16'hffff, 8'h06);
    xfer(1'b1, 16'hffff, 8'h00);
    check(st[9:0], 10'h006);
    xfer(1'b0, 16'hffff, 8'h0a);
    expect_busy(1'b1);
    settle;
    xfer(1'b1, 16'hffff, 8'h00);
    check(st[9:0], 10'h00a);
    xfer(1'b0, 16'h0c00, 8'h33);
    check(st[9:0] & 10'h200, 10'h000);
    expect_busy(1'b0);
    xfer(1'b0, 16'h0bff, 8'h44);
    expect_busy(1'b1);
    settle;
    xfer(1'b1, 16'h0c00, 8'h00);
    check(st[9:0], 10'h0a5);
    xfer(1'b1, 16'h0bff, 8'h00);
    check(st[9:0], 10'h044);
    $display("test lock done");
    // pin plus enable freeze the register, open array still writes
    xfer(1'b0, 16'hffff, 8'h06);
    xfer(1'b0, 16'hffff, 8'h82);
    settle;
    wp <= 1'b1;
    xfer(1'b0, 16'hffff, 8'h06);
    xfer(1'b0, 16'hffff, 8'h9a);
    expect_busy(1'b0);
    xfer(1'b1, 16'hffff, 8'h00);
    check(st[9:0], 10'h082);
    xfer(1'b0, 16'h0c00, 8'h77);
    expect_busy(1'b1);
    settle;
    // cleared write latch refuses array data
    xfer(1'b0, 16'hffff, 8'h00);
    xfer(1'b1, 16'hffff, 8'h00);
    check(st[9:0], 10'h080);
    xfer(1'b0, 16'h0010, 8'h99);
    check(st[9:0] & 10'h200, 10'h200);
    xfer(1'b1, 16'h0c00, 8'h00);
    check(st[9:0], 10'h077);
    $display("test hardware protect done");
    print_verdict;
  end
endmodule : tb
